// [include/esr_regs.svh]
`ifndef ESR_REGS_SVH
`define ESR_REGS_SVH

// one stored byte: eight data bits and their parity bit
`define ESR_LANE_BITS     9
`define ESR_SMALL_BITS    576
`define ESR_MED_BITS      4608
`define ESR_LARGE_BITS    589824
`define ESR_DEF_WIDTH     36
`define ESR_CLR_BIT       1'b0
`define ESR_SET_BIT       1'b1
`define ESR_DONT_CARE_BIT 1'b1

`endif

// [include/esr_pkg.sv]
package esr_pkg;

    typedef enum logic [1:0] {
        ESR_SMALL,
        ESR_MEDIUM,
        ESR_LARGE
    } esr_variant_t;

    typedef enum logic [2:0] {
        ESR_MODE_SP,
        ESR_MODE_SDP,
        ESR_MODE_TDP,
        ESR_MODE_ROM,
        ESR_MODE_FIFO,
        ESR_MODE_DUAL_SP
    } esr_mode_t;

endpackage : esr_pkg

// [include/esr_port_if.sv]
`timescale 1ns/10ps
interface esr_port_if #(
    parameter int AW = 7,
    parameter int DW = 36,
    parameter int BW = 4
);
    logic [AW-1:0] addr;
    logic [DW-1:0] din;
    logic [BW-1:0] be;
    logic          we_stb;
    logic          re_stb;

    modport src (output addr, output din, output be, output we_stb, output re_stb);
    modport dst (input addr, input din, input be, input we_stb, input re_stb);
endinterface : esr_port_if

// [rtl/esr_port_regs.sv]
`timescale 1ns/10ps
`include "esr_regs.svh"
module esr_port_regs #(
    parameter int AW     = 7,
    parameter int DW     = 36,
    parameter int BW     = 4,
    parameter bit CLR_EN = 1'b1
) (
    input  wire logic          core_clk_i,
    input  wire logic          rst_i,
    input  wire logic          in_clr_i,
    input  wire logic          in_ce_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] din_i,
    input  wire logic [BW-1:0] be_i,
    input  wire logic          we_i,
    input  wire logic          re_i,
    esr_port_if.src            port
);
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] din;
        logic [BW-1:0] be;
        logic          we;
        logic          re;
    } esrp_st_t;

    esrp_st_t s_q;
    esrp_st_t s_d;
    logic     arst;

    assign arst = rst_i | (in_clr_i & CLR_EN);

    always_comb begin
        s_d = s_q;
        if (in_ce_i) begin
            s_d.addr = addr_i;
            s_d.din  = din_i;
            s_d.be   = be_i;
        end
        s_d.we = in_ce_i & we_i;
        s_d.re = in_ce_i & re_i;
    end

    always_ff @(posedge core_clk_i or posedge arst) begin
        if (arst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign port.addr   = s_q.addr;
    assign port.din    = s_q.din;
    assign port.be     = s_q.be;
    assign port.we_stb = s_q.we;
    assign port.re_stb = s_q.re;
endmodule : esr_port_regs

// [rtl/esr_out_stage.sv]
`timescale 1ns/10ps
`include "esr_regs.svh"
module esr_out_stage #(
    parameter int DW = 36
) (
    input  wire logic          core_clk_i,
    input  wire logic          rst_i,
    input  wire logic          out_clr_i,
    input  wire logic          out_ce_i,
    input  wire logic          bypass_i,
    input  wire logic [DW-1:0] rd_data_i,
    input  wire logic          rd_stb_i,
    output logic      [DW-1:0] q_o
);
    typedef struct packed {
        logic [DW-1:0] lat;
        logic [DW-1:0] q;
    } esro_st_t;

    esro_st_t s_q;
    esro_st_t s_d;
    logic     arst;

    assign arst = rst_i | out_clr_i;

    always_comb begin
        s_d = s_q;
        if (rd_stb_i) begin
            s_d.lat = rd_data_i;
        end
        if (bypass_i) begin
            if (rd_stb_i) begin
                s_d.q = rd_data_i;
            end
        end else if (out_ce_i) begin
            s_d.q = s_q.lat;
        end
    end

    always_ff @(posedge core_clk_i or posedge arst) begin
        if (arst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q_o = s_q.q;
endmodule : esr_out_stage

// [rtl/esr_top.sv]
`timescale 1ns/10ps
`include "esr_regs.svh"
// Summary of operation
// - every variant: single, simple-dual, ROM, FIFO
// - registered writes, optional read pipeline register
// - true dual port on medium and large: any two operations
// - simple dual collision: old or undefined
// - single port shows written data
// - ports may differ in data width
// - address, data and enables registered, except port B read in flow-through
// - internal self-timed write strobe
// - output registers may be bypassed
// - flow-through port B read on small and medium, in simple dual mode only
// - medium hosts two half-size single ports
// - large clears only output registers
// - input clear zeroes input registers immediately
// - output clear zeroes outputs immediately
// - parity per byte, byte enables except on small
module esr_top #(
    parameter esr_pkg::esr_variant_t VARIANT    = esr_pkg::ESR_MEDIUM,
    parameter int                    TOTAL_BITS = `ESR_MED_BITS,
    parameter int                    A_W        = `ESR_DEF_WIDTH,
    parameter int                    B_W        = `ESR_DEF_WIDTH,
    parameter logic [TOTAL_BITS-1:0] INIT       = '0,
    parameter int                    A_AW       = $clog2(TOTAL_BITS / A_W),
    parameter int                    B_AW       = $clog2(TOTAL_BITS / B_W),
    parameter int                    A_BW       = (A_W + `ESR_LANE_BITS - 1) / `ESR_LANE_BITS,
    parameter int                    B_BW       = (B_W + `ESR_LANE_BITS - 1) / `ESR_LANE_BITS
) (
    input  wire logic                core_clk_i,
    input  wire logic                rst_i,
    input  wire esr_pkg::esr_mode_t  mode_i,
    input  wire logic                rdw_old_i,
    input  wire logic                out_bypass_i,
    input  wire logic                flow_thru_i,
    input  wire logic                in_clr_i,
    input  wire logic                out_clr_i,
    input  wire logic                a_in_ce_i,
    input  wire logic                a_out_ce_i,
    input  wire logic [A_AW-1:0]     a_addr_i,
    input  wire logic [A_W-1:0]      a_din_i,
    input  wire logic [A_BW-1:0]     a_be_i,
    input  wire logic                a_we_i,
    input  wire logic                a_re_i,
    output logic      [A_W-1:0]      a_q_o,
    output logic                     a_q_vld_o,
    input  wire logic                b_in_ce_i,
    input  wire logic                b_out_ce_i,
    input  wire logic [B_AW-1:0]     b_addr_i,
    input  wire logic [B_W-1:0]      b_din_i,
    input  wire logic [B_BW-1:0]     b_be_i,
    input  wire logic                b_we_i,
    input  wire logic                b_re_i,
    output logic      [B_W-1:0]      b_q_o,
    output logic                     b_q_vld_o,
    output logic                     fifo_full_o,
    output logic                     fifo_empty_o
);
    import esr_pkg::*;

    localparam int MW   = (A_W > B_W) ? A_W : B_W;
    localparam int LW   = $clog2(TOTAL_BITS + 1);
    localparam int HALF = TOTAL_BITS / 2;
    localparam bit IS_LARGE = (VARIANT == ESR_LARGE);

    typedef logic [TOTAL_BITS-1:0] esr_mem_t;
    typedef logic [MW-1:0]         esr_word_t;

    typedef struct packed {
        esr_mem_t        mem;
        logic [A_AW-1:0] wptr;
        logic [B_AW-1:0] rptr;
        logic [LW-1:0]   level;
        logic            full;
        logic            empty;
        logic            a_vld;
        logic            b_vld;
    } esr_st_t;

    esr_st_t s_q;
    esr_st_t s_d;

    esr_port_if #(.AW(A_AW), .DW(A_W), .BW(A_BW)) pa ();
    esr_port_if #(.AW(B_AW), .DW(B_W), .BW(B_BW)) pb ();

    esr_mode_t mode;
    logic      flow;
    logic      a_wr;
    logic      b_wr;
    logic      a_rd;
    logic      b_rd;
    logic      push;
    logic      pop;
    logic      coll;
    int unsigned a_base;
    int unsigned b_base;
    esr_word_t a_word;
    esr_word_t b_word;
    logic [A_W-1:0] a_rd_data;
    logic [B_W-1:0] b_rd_data;

    function automatic esr_word_t get_word(esr_mem_t m, int unsigned base);
        esr_word_t r;
        r = '0;
        for (int i = 0; i < MW; i++) begin
            if (base + i < TOTAL_BITS) begin
                r[i] = m[base+i];
            end
        end
        return r;
    endfunction : get_word

    // byte lanes carry their parity bit
    function automatic esr_mem_t put_word(esr_mem_t m, int unsigned base, int unsigned w,
                                          esr_word_t d, logic [MW-1:0] be);
        esr_mem_t r;
        r = m;
        for (int i = 0; i < MW; i++) begin
            if (i < w && be[i / `ESR_LANE_BITS] && base + i < TOTAL_BITS) begin
                r[base+i] = d[i];
            end
        end
        return r;
    endfunction : put_word

    // small variant has no byte enables, so every lane is written
    function automatic logic [MW-1:0] lane_mask(logic [MW-1:0] be);
        return (VARIANT == ESR_SMALL) ? '1 : be;
    endfunction : lane_mask

    always_comb begin
        mode = mode_i;
        if (mode_i == ESR_MODE_TDP && VARIANT == ESR_SMALL) begin
            mode = ESR_MODE_SDP;
        end
        if (mode_i == ESR_MODE_DUAL_SP && VARIANT != ESR_MEDIUM) begin
            mode = ESR_MODE_SP;
        end
    end

    assign flow = flow_thru_i && !IS_LARGE && mode == ESR_MODE_SDP;

    esr_port_regs #(.AW(A_AW), .DW(A_W), .BW(A_BW), .CLR_EN(!IS_LARGE)) u_pa (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .in_clr_i   (in_clr_i),
        .in_ce_i    (a_in_ce_i),
        .addr_i     (a_addr_i),
        .din_i      (a_din_i),
        .be_i       (a_be_i),
        .we_i       (a_we_i),
        .re_i       (a_re_i),
        .port       (pa.src)
    );

    esr_port_regs #(.AW(B_AW), .DW(B_W), .BW(B_BW), .CLR_EN(!IS_LARGE)) u_pb (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .in_clr_i   (in_clr_i),
        .in_ce_i    (b_in_ce_i),
        .addr_i     (b_addr_i),
        .din_i      (b_din_i),
        .be_i       (b_be_i),
        .we_i       (b_we_i),
        .re_i       (b_re_i),
        .port       (pb.src)
    );

    always_comb begin
        s_d = s_q;
        // each port scaled by own width
        a_base = int'(pa.addr) * A_W;
        b_base = flow ? int'(b_addr_i) * B_W : int'(pb.addr) * B_W;
        if (mode == ESR_MODE_FIFO) begin
            a_base = int'(s_q.wptr) * A_W;
            b_base = int'(s_q.rptr) * B_W;
        end
        if (mode == ESR_MODE_DUAL_SP) begin
            a_base = a_base % HALF;
            b_base = (b_base % HALF) + HALF;
        end
        push = pa.we_stb && !s_q.full;
        pop  = pb.re_stb && !s_q.empty;
        a_wr = pa.we_stb && mode != ESR_MODE_ROM && (mode != ESR_MODE_FIFO || push);
        // port B writes in true dual
        b_wr = pb.we_stb && (mode == ESR_MODE_TDP || mode == ESR_MODE_DUAL_SP);
        a_rd = pa.re_stb || (pa.we_stb && (mode == ESR_MODE_SP || mode == ESR_MODE_DUAL_SP));
        a_rd = a_rd && mode != ESR_MODE_FIFO;
        b_rd = (mode == ESR_MODE_FIFO) ? pop
             : (flow ? (b_in_ce_i && b_re_i) : pb.re_stb) || (mode == ESR_MODE_DUAL_SP && b_wr);
        b_rd = b_rd && mode != ESR_MODE_SP;
        a_word = get_word(s_q.mem, a_base);
        b_word = get_word(s_q.mem, b_base);
        if (pa.we_stb && (mode == ESR_MODE_SP || mode == ESR_MODE_DUAL_SP)) begin
            a_word = esr_word_t'(pa.din);
        end
        if (b_wr && mode == ESR_MODE_DUAL_SP) begin
            b_word = esr_word_t'(pb.din);
        end
        coll = a_wr && mode != ESR_MODE_DUAL_SP && a_base < b_base + B_W && b_base < a_base + A_W;
        if (coll && (IS_LARGE || !rdw_old_i)) begin
            b_word = {MW{`ESR_DONT_CARE_BIT}};
        end
        a_rd_data = a_word[A_W-1:0];
        b_rd_data = b_word[B_W-1:0];
        if (a_wr) begin
            s_d.mem = put_word(s_d.mem, a_base, A_W, esr_word_t'(pa.din),
                               lane_mask(esr_word_t'(pa.be)));
        end
        if (b_wr) begin
            s_d.mem = put_word(s_d.mem, b_base, B_W, esr_word_t'(pb.din),
                               lane_mask(esr_word_t'(pb.be)));
        end
        if (mode == ESR_MODE_FIFO) begin
            if (push) begin
                s_d.wptr = s_q.wptr + 1'b1;
            end
            if (pop) begin
                s_d.rptr = s_q.rptr + 1'b1;
            end
            s_d.level = s_q.level + (push ? LW'(A_W) : '0) - (pop ? LW'(B_W) : '0);
        end else begin
            s_d.wptr  = '0;
            s_d.rptr  = '0;
            s_d.level = '0;
        end
        s_d.full  = (int'(s_d.level) + A_W) > TOTAL_BITS;
        s_d.empty = int'(s_d.level) < B_W;
        // large outputs valid after a read
        s_d.a_vld = !IS_LARGE || s_q.a_vld || a_rd;
        s_d.b_vld = !IS_LARGE || s_q.b_vld || b_rd;
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q       <= '0;
            s_q.mem   <= IS_LARGE ? esr_mem_t'(0) : INIT;
            s_q.empty <= `ESR_SET_BIT;
        end else begin
            s_q <= s_d;
        end
    end

    esr_out_stage #(.DW(A_W)) u_qa (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .out_clr_i  (out_clr_i),
        .out_ce_i   (a_out_ce_i),
        .bypass_i   (out_bypass_i),
        .rd_data_i  (a_rd_data),
        .rd_stb_i   (a_rd),
        .q_o        (a_q_o)
    );

    esr_out_stage #(.DW(B_W)) u_qb (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .out_clr_i  (out_clr_i),
        .out_ce_i   (b_out_ce_i),
        .bypass_i   (out_bypass_i | flow),
        .rd_data_i  (b_rd_data),
        .rd_stb_i   (b_rd),
        .q_o        (b_q_o)
    );

    assign a_q_vld_o    = s_q.a_vld;
    assign b_q_vld_o    = s_q.b_vld;
    assign fifo_full_o  = s_q.full;
    assign fifo_empty_o = s_q.empty;
endmodule : esr_top

// [sim/esr_top_properties.sv]
`timescale 1ns/10ps
module esr_top_chk #(
    parameter esr_pkg::esr_variant_t VARIANT = esr_pkg::ESR_MEDIUM,
    parameter int                    A_W     = 36,
    parameter int                    B_W     = 36,
    parameter int                    A_AW    = 7,
    parameter int                    B_AW    = 7,
    parameter int                    A_BW    = 4
) (
    input wire logic               core_clk_i,
    input wire logic               rst_i,
    input wire esr_pkg::esr_mode_t mode_i,
    input wire logic               rdw_old_i,
    input wire logic               out_bypass_i,
    input wire logic               flow_thru_i,
    input wire logic               out_clr_i,
    input wire logic               a_in_ce_i,
    input wire logic               a_out_ce_i,
    input wire logic [A_AW-1:0]    a_addr_i,
    input wire logic [A_W-1:0]     a_din_i,
    input wire logic [A_BW-1:0]    a_be_i,
    input wire logic               a_we_i,
    input wire logic [A_W-1:0]     a_q_o,
    input wire logic               a_q_vld_o,
    input wire logic               b_in_ce_i,
    input wire logic               b_out_ce_i,
    input wire logic [B_AW-1:0]    b_addr_i,
    input wire logic               b_re_i,
    input wire logic [B_W-1:0]     b_q_o,
    input wire logic               b_q_vld_o,
    input wire logic               fifo_full_o,
    input wire logic               fifo_empty_o
);
    import esr_pkg::*;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence sp_wr_s;
        mode_i == ESR_MODE_SP && a_in_ce_i && a_we_i && a_be_i == '1;
    endsequence
    clr_zero_q_a: assert property (out_clr_i |-> a_q_o == '0 && b_q_o == '0)
        else $error("q not zero under clear");
    hold_qa_a: assert property (
        !a_out_ce_i && !out_bypass_i |=> out_clr_i || $stable(a_q_o))
        else $error("port a q moved while disabled");
    hold_qb_a: assert property (
        !b_out_ce_i && !out_bypass_i |=> out_clr_i || $stable(b_q_o))
        else $error("port b q moved while disabled");
    vld_after_rst_a: assert property (
        VARIANT != ESR_LARGE && !$past(rst_i) |-> a_q_vld_o && b_q_vld_o)
        else $error("valid low after reset");
    fifo_idle_flags_a: assert property (
        (mode_i != ESR_MODE_FIFO) [*2] |-> fifo_empty_o && !fifo_full_o)
        else $error("fifo flags outside fifo mode");
    sp_byp_word_a: assert property (
        sp_wr_s ##0 out_bypass_i |-> ##2 out_clr_i || a_q_o == $past(a_din_i, 2))
        else $error("bypassed write word not shown");
    sp_reg_word_a: assert property (
        sp_wr_s ##0 !out_bypass_i ##2 a_out_ce_i
        |-> ##1 out_clr_i || a_q_o == $past(a_din_i, 3))
        else $error("registered write word not shown");
    rdw_undef_ones_a: assert property (
        A_W == B_W && mode_i == ESR_MODE_SDP && a_in_ce_i && b_in_ce_i && a_we_i && b_re_i
        && a_addr_i == b_addr_i && !rdw_old_i && out_bypass_i && !flow_thru_i
        |-> ##2 out_clr_i || b_q_o == '1)
        else $error("collision data not all ones");
    cover property (sp_wr_s);
    cover property (out_clr_i);
    cover property (mode_i == ESR_MODE_TDP && a_we_i && b_re_i);
    cover property (mode_i == ESR_MODE_FIFO && !fifo_empty_o);
endmodule : esr_top_chk
bind esr_top esr_top_chk #(.VARIANT(VARIANT), .A_W(A_W), .B_W(B_W), .A_AW(A_AW), .B_AW(B_AW),
    .A_BW(A_BW)) i_esr_top_chk (.core_clk_i, .rst_i, .mode_i, .rdw_old_i, .out_bypass_i,
    .flow_thru_i, .out_clr_i, .a_in_ce_i, .a_out_ce_i, .a_addr_i, .a_din_i, .a_be_i, .a_we_i,
    .a_q_o, .a_q_vld_o, .b_in_ce_i, .b_out_ce_i, .b_addr_i, .b_re_i, .b_q_o, .b_q_vld_o,
    .fifo_full_o, .fifo_empty_o);

// [sim/esr_user_model.sv]
`timescale 1ns/10ps
module esr_user_model #(
    parameter int AW = 7,
    parameter int DW = 36,
    parameter int BW = 4
) (
    output logic [AW-1:0] addr_o,
    output logic [DW-1:0] din_o,
    output logic [BW-1:0] be_o,
    output logic          we_o,
    output logic          re_o
);
    // released lines flip so a stale copy is never read as valid
    task automatic rel();
        we_o = 1'h0;
        re_o = 1'h0;
        addr_o = ~addr_o;
        din_o = ~din_o;
        be_o = ~be_o;
    endtask : rel
    task automatic put(input logic we, input logic re, input logic [AW-1:0] ad,
                       input logic [DW-1:0] d, input logic [BW-1:0] be);
        re_o = re & ~we;
        we_o = we;
        addr_o = ad;
        din_o = d;
        be_o = be;
    endtask : put
    initial put(1'h0, 1'h0, '0, '0, '0);
endmodule : esr_user_model

// [sim/tb_esr_top.sv]
`timescale 1ns/10ps
`include "esr_regs.svh"
module tb_esr_top;
    import esr_pkg::*;
    localparam int DAT_W = `ESR_DEF_WIDTH;
    localparam int ADR_W = $clog2(`ESR_MED_BITS / DAT_W);
    localparam int BE_W  = DAT_W / `ESR_LANE_BITS;
    localparam int LN    = `ESR_LANE_BITS;
    logic             core_clk_i = 1'h0, rst_i = 1'h1, rdw_old_i = 1'h1, out_bypass_i = 1'h1;
    logic             out_clr_i = 1'h0, a_in_ce_i = 1'h1, a_out_ce_i = 1'h1;
    logic             b_in_ce_i = 1'h1, b_out_ce_i = 1'h1;
    logic             in_clr_i = 1'h0, flow_thru_i = 1'h0, fifo_full_o, fifo_empty_o;
    esr_mode_t        mode_i = ESR_MODE_SDP;
    logic [ADR_W-1:0] a_addr_i, b_addr_i, ads [12];
    logic [DAT_W-1:0] a_din_i, b_din_i, a_q_o, b_q_o, d, w, exp_v, old, mem [2**ADR_W];
    logic [BE_W-1:0]  a_be_i, b_be_i;
    logic             a_we_i, a_re_i, b_we_i, b_re_i, a_q_vld_o, b_q_vld_o;
    logic [31:0]      seed = 32'hBF7CA93C;
    int               failures = 0, compares = 0, cycles = 0;

    always #20 core_clk_i = ~core_clk_i;

    esr_user_model i_user_a (.addr_o(a_addr_i), .din_o(a_din_i), .be_o(a_be_i), .we_o(a_we_i),
        .re_o(a_re_i));
    esr_user_model i_user_b (.addr_o(b_addr_i), .din_o(b_din_i), .be_o(b_be_i), .we_o(b_we_i),
        .re_o(b_re_i));
    esr_top i_esr_top (.core_clk_i, .rst_i, .mode_i, .rdw_old_i, .out_bypass_i, .flow_thru_i,
        .in_clr_i, .out_clr_i, .a_in_ce_i, .a_out_ce_i, .a_addr_i, .a_din_i, .a_be_i, .a_we_i,
        .a_re_i, .a_q_o, .a_q_vld_o, .b_in_ce_i, .b_out_ce_i, .b_addr_i, .b_din_i, .b_be_i, .b_we_i,
        .b_re_i, .b_q_o, .b_q_vld_o, .fifo_full_o, .fifo_empty_o);

    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    function automatic logic [DAT_W-1:0] merge(input logic [DAT_W-1:0] o,
                                               input logic [DAT_W-1:0] n,
                                               input logic [BE_W-1:0] be);
        for (int i = 0; i < BE_W; i++) begin
            if (be[i]) begin
                o[i*LN +: LN] = n[i*LN +: LN];
            end
        end
        return o;
    endfunction : merge
    task automatic draw(output logic [DAT_W-1:0] v);
        logic [31:0] t;
        t = nxt(seed);
        seed = nxt(t);
        v = {seed[3:0], t};
    endtask : draw
    task automatic check(input logic [DAT_W-1:0] seen, input logic [DAT_W-1:0] expv);
        compares++;
        if (seen !== expv) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check
    task automatic complete_run();
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic step();
        @(negedge core_clk_i);
        i_user_a.rel();
        i_user_b.rel();
    endtask : step
    task automatic wr(input logic [ADR_W-1:0] ad, input logic [DAT_W-1:0] dd,
                      input logic [BE_W-1:0] be);
        @(negedge core_clk_i);
        i_user_a.put(1'h1, 1'h0, ad, dd, be);
        mem[ad] = merge(mem[ad], dd, be);
        step();
    endtask : wr
    task automatic rd(input logic pb, input logic [ADR_W-1:0] ad);
        @(negedge core_clk_i);
        if (pb) begin
            i_user_b.put(1'h0, 1'h1, ad, '0, '0);
        end else begin
            i_user_a.put(1'h0, 1'h1, ad, '0, '0);
        end
        step();
        @(negedge core_clk_i);
    endtask : rd

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            complete_run();
        end
    end

    initial begin
        for (int i = 0; i < 2**ADR_W; i++) begin
            mem[i] = '0;
        end
        repeat (16) @(negedge core_clk_i);
        check(a_q_o, '0); // cleared outputs
        check(b_q_o, '0); // cleared outputs
        rst_i = 1'h0;
        repeat (2) @(negedge core_clk_i);
        check(DAT_W'({a_q_vld_o, b_q_vld_o}), 36'h3); // valid after reset
        for (int i = 0; i < 12; i++) begin
            draw(w);
            ads[i] = (i == 0) ? '0 : (i == 1) ? '1 : w[ADR_W-1:0];
            draw(d);
            wr(ads[i], d, '1);
        end
        for (int i = 0; i < 12; i++) begin
            rd(1'h1, ads[i]);
            check(b_q_o, mem[ads[i]]); // read back
        end
        draw(d);
        wr(ads[2], d, 4'h5);
        rd(1'h1, ads[2]);
        check(b_q_o, mem[ads[2]]); // lane mask
        for (int k = 0; k < 2; k++) begin
            draw(d);
            @(negedge core_clk_i);
            rdw_old_i = (k == 0);
            exp_v = (k == 0) ? mem[ads[3]] : '1;
            i_user_a.put(1'h1, 1'h0, ads[3], d, '1);
            i_user_b.put(1'h0, 1'h1, ads[3], '0, '0);
            mem[ads[3]] = d;
            step();
            @(negedge core_clk_i);
            check(b_q_o, exp_v); // same address
        end
        rdw_old_i = 1'h1;
        out_bypass_i = 1'h0;
        rd(1'h1, ads[4]);
        @(negedge core_clk_i);
        check(b_q_o, mem[ads[4]]); // pipelined read
        a_out_ce_i = 1'h0;
        b_out_ce_i = 1'h0;
        rd(1'h1, ads[5]);
        @(negedge core_clk_i);
        check(b_q_o, mem[ads[4]]); // output held
        a_out_ce_i = 1'h1;
        b_out_ce_i = 1'h1;
        out_clr_i = 1'h1;
        #5;
        check(a_q_o, '0); // cleared at once
        check(b_q_o, '0); // cleared at once
        @(negedge core_clk_i);
        out_clr_i = 1'h0;
        for (int k = 0; k < 2; k++) begin
            // first pass input enable low, second pass ROM: contents already written, later writes refused
            mode_i = k ? ESR_MODE_ROM : ESR_MODE_SDP;
            a_in_ce_i = k[0];
            old = mem[ads[6+k]];
            wr(ads[6+k], ~old, '1);
            mem[ads[6+k]] = old;
            a_in_ce_i = 1'h1;
            rd(!k[0], ads[6+k]);
            @(negedge core_clk_i);
            check(k ? a_q_o : b_q_o, old); // write refused
        end
        mode_i = ESR_MODE_SP;
        for (int k = 0; k < 2; k++) begin
            out_bypass_i = !k[0];
            draw(d);
            wr(ads[8], d, '1);
            repeat (k + 1) @(negedge core_clk_i);
            check(a_q_o, d); // written word shown
        end
        mode_i = ESR_MODE_SDP;
        out_bypass_i = 1'h1;
        flow_thru_i = 1'h1;
        @(negedge core_clk_i);
        i_user_b.put(1'h0, 1'h1, ads[1], '0, '0);
        @(negedge core_clk_i);
        check(b_q_o, mem[ads[1]]); // flow-through after one edge
        i_user_b.rel();
        flow_thru_i = 1'h0;
        old = mem[ads[11]];
        @(negedge core_clk_i);
        i_user_a.put(1'h1, 1'h0, ads[11], ~old, '1);
        step();
        in_clr_i = 1'h1;
        @(negedge core_clk_i);
        in_clr_i = 1'h0;
        rd(1'h1, ads[11]);
        check(b_q_o, old); // captured write cleared
        for (int k = 0; k < 2; k++) begin
            // second pass: two half-size single ports on one address
            mode_i = k ? ESR_MODE_DUAL_SP : ESR_MODE_TDP;
            draw(d);
            draw(w);
            @(negedge core_clk_i);
            i_user_a.put(1'h1, 1'h0, ads[9], d, '1);
            i_user_b.put(1'h1, 1'h0, ads[10-k], w, '1);
            if (k == 0) begin
                mem[ads[9]] = d;
                mem[ads[10]] = w;
            end
            step();
            @(negedge core_clk_i);
            i_user_a.put(1'h0, 1'h1, ads[10-k], '0, '0);
            i_user_b.put(1'h0, 1'h1, ads[9], '0, '0);
            step();
            @(negedge core_clk_i);
            check(a_q_o, k ? d : mem[ads[10]]); // both ports
            check(b_q_o, k ? w : mem[ads[9]]); // both ports
        end
        mode_i = ESR_MODE_FIFO;
        draw(d);
        draw(w);
        @(negedge core_clk_i);
        check(DAT_W'({fifo_full_o, fifo_empty_o}), 36'h1); // fifo starts empty
        wr(ads[0], d, '1);
        wr(ads[0], w, '1);
        @(negedge core_clk_i);
        check(DAT_W'({fifo_full_o, fifo_empty_o}), 36'h0); // fifo holds words
        rd(1'h1, ads[0]);
        check(b_q_o, d); // first word out first
        rd(1'h1, ads[0]);
        check(b_q_o, w); // second word out
        check(DAT_W'({fifo_full_o, fifo_empty_o}), 36'h1); // fifo drained
        complete_run();
    end
endmodule : tb_esr_top
